// File: logic/dcsc_top.sv
/*
 Control logic of four output offset servo channels: enables,
 start-up and stored-value corrections, status and interrupt.
 Assumes one 20 MHz clock, synchronous inputs and a comparator
 per channel telling whether the output sits above ground.
*/
// Decided for this implementation: the address-and-strobe port.
// What this block does
// [R1] Four servo channels: headphone left/right, line left/right, holding output near ground.
// [R2] Enable register bits 0..3 enable headphone L, headphone R, line L, line R.
// [R3] Correction commands act only on channels whose enable bit is set.
// [R4] Start-up trigger runs a measured correction series on that channel.
// [R5] Start-up triggers at trigger bits 7:4, read as 1 while running.
// [R6] Finished start-up correction sets the channel's start-up-complete flag.
// [R7] Start-up correction lasts about 86 ms per channel.
// [R8] Stored-value trigger loads the channel's offset register as correction.
// [R9] Stored-value triggers at trigger bits 3:0, read as 1 while running.
// [R10] Stored-value correction lasts about 2 ms, then sets its complete flag.
// [R11] Calibration-complete equals start-up-complete OR stored-value-complete.
// [R12] Offset registers hold 8-bit two's complement, 0.25 mV steps, reset zero.
// [R13] Reading an offset register returns the correction now applied.
// [R14] Offset registers at 49h line R, 4Ah line L, 4Bh hp R, 4Ch hp L.
// [R15] Correction stays applied until a later command changes it.
// [R16] Host should run corrections only with headphone outputs muted and shorted.
// [R17] Status register: calibration 11:8, stored 7:4, start-up 3:0.
// [R18] Triggers clear themselves at the end; writing 0 changes nothing.
`timescale 1ns/1ps
`include "dcsc_params.svh"

module dcsc_top #(
    parameter int STARTUP_CYCLES = `DCSC_STARTUP_US * `DCSC_CLK_MHZ,
    parameter int STORED_CYCLES = `DCSC_STORED_US * `DCSC_CLK_MHZ,
    parameter int STEP_CYCLES = `DCSC_STEP_US * `DCSC_CLK_MHZ
) (
    input wire logic CLOCK,
    input wire logic RST,
    input wire dcsc_pkg::dcsc_bus_req_t BUS,
    input wire logic [3:0] SENSE_ABOVE_GND,
    output logic [15:0] RDATA,
    output dcsc_pkg::dcsc_corr_t OFFSET_CORR,
    output logic [3:0] SERVO_ON,
    output logic IRQ
);
    import dcsc_pkg::*;

    localparam int CNT_MAX = (STARTUP_CYCLES > STORED_CYCLES) ?
        STARTUP_CYCLES : STORED_CYCLES;
    localparam int CNT_W = $clog2(CNT_MAX + 1);
    localparam int STEP_W = $clog2(STEP_CYCLES + 1);

    if (STARTUP_CYCLES < 2 || STORED_CYCLES < 2 || STEP_CYCLES < 1) begin : g_chk
        $error("dcsc_top: cycle counts too small");
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [7:0] val_addr(input int ch);
        val_addr = `DCSC_ADDR_VAL_HL - 8'(ch);
    endfunction

    function automatic logic [7:0] servo_step(input logic [7:0] v,
                                              input logic above);
        servo_step = v;
        if (above && v != `DCSC_VAL_MIN) begin
            servo_step = v - `DCSC_STEP_UP;
        end else if (!above && v != `DCSC_VAL_MAX) begin
            servo_step = v + `DCSC_STEP_UP;
        end
    endfunction

    function automatic logic is_wr(input dcsc_bus_req_t r,
                                   input logic [7:0] a);
        is_wr = r.wr && r.addr == a;
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [3:0] en_r;
    logic [7:0] val_r [4];
    logic [7:0] corr_r [4];
    dcsc_ch_state_t st_r [4];
    logic [CNT_W-1:0] cnt_r [4];
    logic [3:0] su_done_r;
    logic [3:0] sv_done_r;
    logic [7:0] irq_st_r;
    logic [7:0] irq_mask_r;
    logic [STEP_W-1:0] div_r;
    logic step_r;
    logic [15:0] rdata_nxt;
    logic [3:0] su_busy;
    logic [3:0] sv_busy;
    logic [3:0] su_go;
    logic [3:0] sv_go;
    logic [3:0] su_fin;
    logic [3:0] sv_fin;
    logic [7:0] irq_clr;

    // ----------------------------------------
    // Command decode and completion
    // ----------------------------------------
    always_comb begin
        for (int c = 0; c < 4; c++) begin
            su_busy[c] = st_r[c] == CH_STARTUP; // R5
            sv_busy[c] = st_r[c] == CH_STORED; // R9
            su_go[c] = is_wr(BUS, `DCSC_ADDR_TRIG) && en_r[c] && // R3
                BUS.wdata[`DCSC_TRIG_SU_LSB + c] && st_r[c] == CH_IDLE; // R4
            sv_go[c] = is_wr(BUS, `DCSC_ADDR_TRIG) && en_r[c] && // R3
                BUS.wdata[`DCSC_TRIG_SV_LSB + c] && st_r[c] == CH_IDLE &&
                !su_go[c]; // R8
            su_fin[c] = su_busy[c] && en_r[c] &&
                cnt_r[c] == CNT_W'(STARTUP_CYCLES - 1); // R7
            sv_fin[c] = sv_busy[c] && en_r[c] &&
                cnt_r[c] == CNT_W'(STORED_CYCLES - 1); // R10
        end
    end

    // ----------------------------------------
    // Measurement step divider
    // ----------------------------------------
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            div_r <= '0;
            step_r <= 1'b0;
        end else if (div_r == STEP_W'(STEP_CYCLES - 1)) begin
            div_r <= '0;
            step_r <= 1'b1;
        end else begin
            div_r <= div_r + STEP_W'(1);
            step_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // Software registers
    // ----------------------------------------
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            en_r <= '0;
            irq_mask_r <= '0;
            for (int c = 0; c < 4; c++) begin
                val_r[c] <= `DCSC_VAL_RESET; // R12
            end
        end else begin
            if (is_wr(BUS, `DCSC_ADDR_ENABLE)) begin
                en_r <= BUS.wdata[3:0]; // R2
            end
            if (is_wr(BUS, `DCSC_ADDR_IRQ_MASK)) begin
                irq_mask_r <= BUS.wdata[7:0];
            end
            for (int c = 0; c < 4; c++) begin
                if (is_wr(BUS, val_addr(c))) begin
                    val_r[c] <= BUS.wdata[7:0]; // R14
                end
            end
        end
    end

    // ----------------------------------------
    // Channel sequencers
    // ----------------------------------------
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            for (int c = 0; c < 4; c++) begin
                st_r[c] <= CH_IDLE;
                cnt_r[c] <= '0;
            end
        end else begin
            for (int c = 0; c < 4; c++) begin
                unique case (st_r[c])
                    CH_IDLE: begin
                        cnt_r[c] <= '0;
                        if (su_go[c]) begin
                            st_r[c] <= CH_STARTUP; // R4
                        end else if (sv_go[c]) begin
                            st_r[c] <= CH_STORED; // R8
                        end
                    end
                    CH_STARTUP, CH_STORED: begin
                        cnt_r[c] <= cnt_r[c] + CNT_W'(1);
                        if (!en_r[c] || su_fin[c] || sv_fin[c]) begin
                            st_r[c] <= CH_IDLE; // R18
                        end
                    end
                    default: begin
                        st_r[c] <= CH_IDLE;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // Applied correction
    // ----------------------------------------
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            for (int c = 0; c < 4; c++) begin
                corr_r[c] <= `DCSC_VAL_RESET; // R12
            end
        end else begin
            for (int c = 0; c < 4; c++) begin
                if (sv_fin[c]) begin
                    corr_r[c] <= val_r[c]; // R8
                end else if (su_busy[c] && en_r[c] && step_r) begin
                    corr_r[c] <= servo_step(corr_r[c], SENSE_ABOVE_GND[c]); // R1
                end
            end
        end
    end

    // ----------------------------------------
    // Completion flags
    // ----------------------------------------
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            su_done_r <= '0;
            sv_done_r <= '0;
        end else begin
            for (int c = 0; c < 4; c++) begin
                if (su_fin[c]) begin
                    su_done_r[c] <= 1'b1; // R6
                end else if (su_go[c] || sv_go[c]) begin
                    su_done_r[c] <= 1'b0;
                end
                if (sv_fin[c]) begin
                    sv_done_r[c] <= 1'b1; // R10
                end else if (su_go[c] || sv_go[c]) begin
                    sv_done_r[c] <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------
    // Interrupt status, cleared by reading
    // ----------------------------------------
    always_comb begin
        irq_clr = '0;
        if (BUS.rd && BUS.addr == `DCSC_ADDR_IRQ_ST) begin
            irq_clr = '1;
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            irq_st_r <= '0;
            IRQ <= 1'b0;
        end else begin
            irq_st_r <= (irq_st_r & ~irq_clr) | {sv_fin, su_fin};
            IRQ <= |(irq_st_r & irq_mask_r);
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    always_comb begin
        rdata_nxt = '0;
        unique case (BUS.addr)
            `DCSC_ADDR_ENABLE: rdata_nxt[3:0] = en_r;
            `DCSC_ADDR_TRIG: begin
                rdata_nxt[`DCSC_TRIG_SU_LSB +: 4] = su_busy; // R5
                rdata_nxt[`DCSC_TRIG_SV_LSB +: 4] = sv_busy; // R9
            end
            `DCSC_ADDR_VAL_LR: rdata_nxt[7:0] = corr_r[3]; // R13
            `DCSC_ADDR_VAL_LL: rdata_nxt[7:0] = corr_r[2]; // R13
            `DCSC_ADDR_VAL_HR: rdata_nxt[7:0] = corr_r[1]; // R13
            `DCSC_ADDR_VAL_HL: rdata_nxt[7:0] = corr_r[0]; // R13
            `DCSC_ADDR_STATUS: begin
                rdata_nxt[`DCSC_STAT_CAL_LSB +: 4] = su_done_r | sv_done_r; // R11
                rdata_nxt[`DCSC_STAT_SV_LSB +: 4] = sv_done_r; // R17
                rdata_nxt[`DCSC_STAT_SU_LSB +: 4] = su_done_r; // R17
            end
            `DCSC_ADDR_IRQ_ST: rdata_nxt[7:0] = irq_st_r;
            `DCSC_ADDR_IRQ_MASK: rdata_nxt[7:0] = irq_mask_r;
            default: rdata_nxt = '0;
        endcase
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            RDATA <= '0;
        end else if (BUS.rd) begin
            RDATA <= rdata_nxt;
        end else begin
            RDATA <= '0;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            SERVO_ON <= '0;
            OFFSET_CORR <= '0;
        end else begin
            SERVO_ON <= en_r;
            for (int c = 0; c < 4; c++) begin
                OFFSET_CORR[c] <= corr_r[c]; // R15
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    logic [CNT_W-1:0] dur_r [4];

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            for (int c = 0; c < 4; c++) begin
                dur_r[c] <= '0;
            end
        end else begin
            for (int c = 0; c < 4; c++) begin
                dur_r[c] <= (st_r[c] == CH_IDLE) ? '0 : dur_r[c] + CNT_W'(1);
            end
        end
    end

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    sequence s_status_rd;
        BUS.rd && BUS.addr == `DCSC_ADDR_STATUS;
    endsequence

    sequence s_trig_rd;
        BUS.rd && BUS.addr == `DCSC_ADDR_TRIG;
    endsequence

    AST_CAL_OR: assert property (s_status_rd |=> // R11
        RDATA[`DCSC_STAT_CAL_LSB +: 4] ==
        (RDATA[`DCSC_STAT_SV_LSB +: 4] | RDATA[`DCSC_STAT_SU_LSB +: 4]))
        else $error("calibration flags not the OR of the two");

    AST_IRQ_LEVEL: assert property ((|(irq_st_r & irq_mask_r)) |=> IRQ)
        else $error("interrupt not raised");

    AST_IRQ_QUIET: assert property (!(|(irq_st_r & irq_mask_r)) |=> !IRQ)
        else $error("interrupt raised with nothing pending");

    for (genvar c = 0; c < 4; c++) begin : g_ast
        sequence s_trig_wr(int b);
            is_wr(BUS, `DCSC_ADDR_TRIG) && BUS.wdata[b];
        endsequence

        AST_NO_START_DISABLED: assert property ( // R3
            (s_trig_wr(`DCSC_TRIG_SU_LSB + c) or s_trig_wr(`DCSC_TRIG_SV_LSB + c))
            ##0 (!en_r[c] && st_r[c] == CH_IDLE) |=> st_r[c] == CH_IDLE)
            else $error("correction started on a disabled channel");

        AST_SU_READBACK: assert property (s_trig_rd |=> // R5
            RDATA[`DCSC_TRIG_SU_LSB + c] == $past(su_busy[c]))
            else $error("start-up progress readback wrong");

        AST_SV_READBACK: assert property (s_trig_rd |=> // R9
            RDATA[`DCSC_TRIG_SV_LSB + c] == $past(sv_busy[c]))
            else $error("stored-value progress readback wrong");

        AST_SU_TIME: assert property ($rose(su_done_r[c]) |-> // R7
            $past(dur_r[c]) == CNT_W'(STARTUP_CYCLES - 1) && !su_busy[c])
            else $error("start-up correction length wrong");

        AST_SV_LOAD: assert property ($rose(sv_done_r[c]) |-> // R8
            corr_r[c] == $past(val_r[c]) &&
            $past(dur_r[c]) == CNT_W'(STORED_CYCLES - 1))
            else $error("stored value not applied on time");

        AST_HOLD: assert property ((st_r[c] == CH_IDLE) ##1 // R15
            (st_r[c] == CH_IDLE) |-> $stable(corr_r[c]))
            else $error("correction moved while idle");

        AST_SELF_CLEAR: assert property ($fell(su_busy[c] | sv_busy[c]) |-> // R18
            $past(su_fin[c] || sv_fin[c] || !en_r[c]))
            else $error("trigger cleared before its end");
    end

endmodule

// File: common/dcsc_params.svh
/*
 Constants of the offset servo control block: register offsets,
 field positions, reset values and timing figures.
 Assumes a single 20 MHz system clock.
*/
`ifndef DCSC_PARAMS_SVH
`define DCSC_PARAMS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DCSC_ADDR_ENABLE 8'h43
`define DCSC_ADDR_TRIG 8'h44
`define DCSC_ADDR_VAL_LR 8'h49
`define DCSC_ADDR_VAL_LL 8'h4A
`define DCSC_ADDR_VAL_HR 8'h4B
`define DCSC_ADDR_VAL_HL 8'h4C
`define DCSC_ADDR_STATUS 8'h4D
`define DCSC_ADDR_IRQ_ST 8'h4E
`define DCSC_ADDR_IRQ_MASK 8'h4F

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DCSC_TRIG_SU_LSB 4
`define DCSC_TRIG_SV_LSB 0
`define DCSC_STAT_CAL_LSB 8
`define DCSC_STAT_SV_LSB 4
`define DCSC_STAT_SU_LSB 0
`define DCSC_IRQ_SV_LSB 4

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define DCSC_VAL_RESET 8'h00
`define DCSC_VAL_MAX 8'h7F
`define DCSC_VAL_MIN 8'h80
`define DCSC_STEP_UP 8'h01

// ----------------------------------------
// Timing
// ----------------------------------------
`define DCSC_CLK_MHZ 20
`define DCSC_STARTUP_US 86000
`define DCSC_STORED_US 2000
`define DCSC_STEP_US 640

`endif

// File: common/dcsc_pkg.sv
/*
 Types of the offset servo control block.
 Assumes dcsc_params.svh for the numbers.
*/
package dcsc_pkg;

    // ----------------------------------------
    // Register bus request
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } dcsc_bus_req_t;

    // ----------------------------------------
    // Per-channel correction words, index 0 = headphone left
    // ----------------------------------------
    typedef logic [3:0][7:0] dcsc_corr_t;

    // ----------------------------------------
    // Channel sequencing states
    // ----------------------------------------
    typedef enum logic [1:0] {
        CH_IDLE = 2'b00,
        CH_STARTUP = 2'b01,
        CH_STORED = 2'b10
    } dcsc_ch_state_t;

endpackage

// File: test/dcsc_top_tb.sv
/*
 Self-checking bench of the offset servo control block.
 Drives the register port and comparator inputs directly,
 with shortened cycle counts for both correction kinds.
*/
`timescale 1ns/1ps
`include "dcsc_params.svh"

module dcsc_top_tb;
    import dcsc_pkg::*;

    localparam int SU_CYC = 40;
    localparam int SV_CYC = 20;
    localparam int ST_CYC = 4;
    localparam logic [7:0] RST_ADDRS [10] = '{`DCSC_ADDR_ENABLE, `DCSC_ADDR_TRIG,
        `DCSC_ADDR_VAL_LR, `DCSC_ADDR_VAL_LL, `DCSC_ADDR_VAL_HR, `DCSC_ADDR_VAL_HL,
        `DCSC_ADDR_STATUS, `DCSC_ADDR_IRQ_ST, `DCSC_ADDR_IRQ_MASK, 8'h50};

    logic clock;
    logic rst;
    dcsc_bus_req_t bus;
    logic [3:0] sense;
    logic [15:0] rdata;
    dcsc_corr_t corr;
    logic [3:0] servo_on;
    logic irq;
    int mismatches;
    int n_checks;

    dcsc_top #(
        .STARTUP_CYCLES(SU_CYC),
        .STORED_CYCLES(SV_CYC),
        .STEP_CYCLES(ST_CYC)
    ) DUT (
        .CLOCK(clock),
        .RST(rst),
        .BUS(bus),
        .SENSE_ABOVE_GND(sense),
        .RDATA(rdata),
        .OFFSET_CORR(corr),
        .SERVO_ON(servo_on),
        .IRQ(irq)
    );

    // ----------------------------------------
    // Clock and helpers
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        bus <= '0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clock);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        bus <= '0;
        #1;
        check(rdata, exp);
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic do_reset();
        @(posedge clock);
        rst <= 1'b1;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
    endtask

    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Watchdog
    // ----------------------------------------
    initial begin
        repeat (5000) @(posedge clock);
        mismatches++;
        wrap_up();
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        bus = '0;
        sense = 4'h0;
        mismatches = 0;
        n_checks = 0;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        // Reset values, unmapped address included
        for (int i = 0; i < 10; i++) begin
            rchk(RST_ADDRS[i], 16'h0000);
        end
        check({corr[1:0]}, 16'h0000);
        check({11'h000, irq, servo_on}, 16'h0000);
        // Offset store without trigger: readback is applied value
        wr(`DCSC_ADDR_VAL_HL, 16'h0085);
        wr(`DCSC_ADDR_VAL_LR, 16'h007F);
        rchk(`DCSC_ADDR_VAL_HL, 16'h0000);
        // Trigger on disabled channels is ignored
        wr(`DCSC_ADDR_TRIG, 16'h0009);
        rchk(`DCSC_ADDR_TRIG, 16'h0000);
        cycles(SV_CYC + 4);
        rchk(`DCSC_ADDR_STATUS, 16'h0000);
        check({8'h00, corr[0]}, 16'h0000);
        // Enable all channels
        wr(`DCSC_ADDR_ENABLE, 16'h000F);
        rchk(`DCSC_ADDR_ENABLE, 16'h000F);
        check({12'h000, servo_on}, 16'h000F);
        // Stored-value load on line right and headphone left, irq masked
        wr(`DCSC_ADDR_IRQ_MASK, 16'h0000);
        wr(`DCSC_ADDR_TRIG, 16'h0009);
        rchk(`DCSC_ADDR_TRIG, 16'h0009);
        cycles(SV_CYC - 6);
        rchk(`DCSC_ADDR_TRIG, 16'h0009);
        cycles(4);
        rchk(`DCSC_ADDR_TRIG, 16'h0000);
        rchk(`DCSC_ADDR_STATUS, 16'h0990);
        check({8'h00, corr[0]}, 16'h0085);
        check({8'h00, corr[3]}, 16'h007F);
        rchk(`DCSC_ADDR_VAL_HL, 16'h0085);
        rchk(`DCSC_ADDR_VAL_LR, 16'h007F);
        check({15'h0000, irq}, 16'h0000);
        // Unmask: level irq rises, read clears it
        wr(`DCSC_ADDR_IRQ_MASK, 16'h00F0);
        cycles(2);
        check({15'h0000, irq}, 16'h0001);
        rchk(`DCSC_ADDR_IRQ_ST, 16'h0090);
        cycles(2);
        check({15'h0000, irq}, 16'h0000);
        rchk(`DCSC_ADDR_IRQ_ST, 16'h0000);
        // Start-up on headphone right (above ground) and line left (below)
        @(posedge clock);
        sense <= 4'b0010;
        wr(`DCSC_ADDR_IRQ_MASK, 16'h000F);
        // Outputs taken as muted and shorted around each trigger
        wr(`DCSC_ADDR_TRIG, 16'h0060);
        rchk(`DCSC_ADDR_TRIG, 16'h0060);
        wr(`DCSC_ADDR_TRIG, 16'h0000);
        rchk(`DCSC_ADDR_TRIG, 16'h0060);
        cycles(SU_CYC - 10);
        rchk(`DCSC_ADDR_TRIG, 16'h0060);
        cycles(8);
        rchk(`DCSC_ADDR_TRIG, 16'h0000);
        rchk(`DCSC_ADDR_STATUS, 16'h0F96);
        check({8'h00, corr[1][7], corr[2][7], 6'h00}, 16'h0080);
        check({15'h0000, corr[2] == 8'h00}, 16'h0000);
        check({8'h00, corr[0]}, 16'h0085);
        check({15'h0000, irq}, 16'h0001);
        rchk(`DCSC_ADDR_IRQ_ST, 16'h0006);
        cycles(2);
        check({15'h0000, irq}, 16'h0000);
        // Abort a run by clearing its enable
        wr(`DCSC_ADDR_TRIG, 16'h0020);
        rchk(`DCSC_ADDR_TRIG, 16'h0020);
        wr(`DCSC_ADDR_ENABLE, 16'h000D);
        cycles(2);
        check({12'h000, servo_on}, 16'h000D);
        rchk(`DCSC_ADDR_TRIG, 16'h0000);
        cycles(SU_CYC + 4);
        rchk(`DCSC_ADDR_STATUS, 16'h0D94);
        wr(`DCSC_ADDR_TRIG, 16'h0002);
        rchk(`DCSC_ADDR_TRIG, 16'h0000);
        // Read-only status and unmapped write
        wr(`DCSC_ADDR_STATUS, 16'hFFFF);
        rchk(`DCSC_ADDR_STATUS, 16'h0D94);
        wr(8'h50, 16'hFFFF);
        rchk(8'h50, 16'h0000);
        // Second reset in mid-run
        wr(`DCSC_ADDR_TRIG, 16'h0001);
        do_reset();
        rchk(`DCSC_ADDR_ENABLE, 16'h0000);
        rchk(`DCSC_ADDR_STATUS, 16'h0000);
        rchk(`DCSC_ADDR_VAL_HL, 16'h0000);
        check(corr[1:0], 16'h0000);
        check(corr[3:2], 16'h0000);
        wrap_up();
    end

endmodule
